/* hdl/dsr_pkg.sv */
package dsr_pkg;
  localparam int DSR_RES_BITS = 12;
  localparam int DSR_NULL_BITS = 4;
  localparam int DSR_FRAME_BITS = DSR_NULL_BITS + DSR_RES_BITS;
  localparam int DSR_CNT_W = 5;
  localparam logic [DSR_CNT_W-1:0] DSR_CNT_ZERO = 5'h00;
  localparam logic [DSR_CNT_W-1:0] DSR_CNT_ONE = 5'h01;
  localparam logic [DSR_CNT_W-1:0] DSR_CNT_LAST_NULL = 5'h04;
  localparam logic [DSR_CNT_W-1:0] DSR_CNT_FIRST_DATA = 5'h05;
  localparam logic [DSR_CNT_W-1:0] DSR_CNT_FRAME = 5'h10;
  localparam logic [DSR_CNT_W-1:0] DSR_CNT_DONE = 5'h11;
  localparam logic [DSR_NULL_BITS-1:0] DSR_NULL_FILL = 4'h0;
  localparam logic [DSR_RES_BITS-1:0] DSR_SIGN_FLIP = 12'h800;
  localparam logic [DSR_RES_BITS-1:0] DSR_WORD_RST = 12'h000;
  localparam logic [DSR_FRAME_BITS-1:0] DSR_FRAME_RST = 16'h0000;
  localparam logic [1:0] DSR_BUF_DEPTH = 2'h2;
  localparam logic [1:0] DSR_BUF_EMPTY = 2'h0;
  localparam logic [1:0] DSR_BUF_STEP = 2'h1;
endpackage

/* hdl/dsr_readout.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - while chip select is low the converter is in its normal active state.
// - while chip select is high the converter is powered down until it goes low again.
// - a falling chip select starts a new sample and conversion.
// - a frame is four null bits then twelve result bits, most significant first.
// - the output changes on each falling serial clock edge and the host samples it on the next rising edge.
// - the serial clock paces the transfer; the conversion is started from chip select in the system clock domain.
// - the twelve-bit result is sent as a two's complement value.
module dsr_readout
  import dsr_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst, // async reset, active high
  input wire logic sclk, // serial clock from host
  input wire logic cs_n, // chip select, active low
  input wire logic [DSR_RES_BITS-1:0] sample_code, // offset-binary code from converter core
  input wire logic sample_valid, // sample_code is offered
  output logic sample_ready, // buffer can take a sample
  output logic conv_start, // one-cycle pulse: sample now
  output logic pwr_down, // core shutdown request
  output logic dout, // serial data out
  output logic dout_oe_n // low while dout is driven
);

  // ----------------------------------------
  // chip select into the system domain
  // ----------------------------------------
  logic cs_s1_q, cs_s2_q, cs_s3_q, cs_lvl_q, cs_lvl_d;
  logic pwr_down_q, conv_start_q;
  wire cs_agree = (cs_s2_q == cs_s3_q);
  wire cs_fall = cs_lvl_q && cs_agree && !cs_s3_q;
  assign cs_lvl_d = cs_agree ? cs_s3_q : cs_lvl_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      cs_lvl_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      cs_lvl_q <= cs_lvl_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwr_down_q <= 1'b1;
      conv_start_q <= 1'b0;
    end else begin
      pwr_down_q <= cs_lvl_q;
      conv_start_q <= cs_fall;
    end
  end

  // ----------------------------------------
  // two-entry sample buffer
  // ----------------------------------------
  logic [DSR_RES_BITS-1:0] buf_mem [2];
  logic wr_ptr_q, rd_ptr_q, ready_q;
  logic [1:0] fill_q, fill_d;
  logic [DSR_RES_BITS-1:0] hold_q;
  logic req_q;
  logic ack_s1_q, ack_s2_q, ack_s3_q, ack_lvl_q;
  logic ack_q; // toggled by the serial side on each take
  wire push = sample_valid && ready_q;
  wire hold_free = (req_q == ack_lvl_q);
  wire pop = (fill_q != DSR_BUF_EMPTY) && hold_free;
  wire [DSR_RES_BITS-1:0] head_code = buf_mem[rd_ptr_q];
  wire [DSR_RES_BITS-1:0] head_signed = head_code ^ DSR_SIGN_FLIP;

  always_comb begin
    fill_d = fill_q;
    if (push && !pop) fill_d = fill_q + DSR_BUF_STEP;
    else if (pop && !push) fill_d = fill_q - DSR_BUF_STEP;
  end

  always_ff @(posedge clock) begin
    if (push) buf_mem[wr_ptr_q] <= sample_code;
  end

  // a stalled host leaves the hold word offered, never taken, so the buffer fills and ready drops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      fill_q <= DSR_BUF_EMPTY;
      ready_q <= 1'b1;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      fill_q <= fill_d;
      ready_q <= (fill_d < DSR_BUF_DEPTH);
    end
  end

  // hold word is stable while req and ack differ
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_q <= DSR_WORD_RST;
      req_q <= 1'b0;
    end else if (pop) begin
      hold_q <= head_signed;
      req_q <= ~req_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      ack_lvl_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      if (ack_s2_q == ack_s3_q) ack_lvl_q <= ack_s3_q;
    end
  end

  // ----------------------------------------
  // serial clock domain
  // ----------------------------------------
  logic req_s1_q, req_s2_q, req_s3_q;
  logic [DSR_RES_BITS-1:0] word_q;
  logic [DSR_CNT_W-1:0] bit_cnt_q;
  logic [DSR_FRAME_BITS-1:0] shreg_q;
  logic dout_q, dout_oe_n_q;
  wire frame_first = (bit_cnt_q == DSR_CNT_ZERO);
  wire take = frame_first && (req_s2_q == req_s3_q) && (req_s3_q != ack_q);
  wire [DSR_RES_BITS-1:0] frame_word = take ? hold_q : word_q; // stale word resent if none new
  wire [DSR_FRAME_BITS-1:0] frame_bits = {DSR_NULL_FILL, frame_word};

  // sclk may stop between frames; these only need to survive, not advance
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      ack_q <= 1'b0;
      word_q <= DSR_WORD_RST;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      if (take) begin
        ack_q <= ~ack_q;
        word_q <= hold_q;
      end
    end
  end

  // chip select high clears the frame and releases the pin at once
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= DSR_CNT_ZERO;
      shreg_q <= DSR_FRAME_RST;
      dout_q <= 1'b0;
      dout_oe_n_q <= 1'b1;
    end else begin
      dout_oe_n_q <= 1'b0;
      if (bit_cnt_q != DSR_CNT_DONE) bit_cnt_q <= bit_cnt_q + DSR_CNT_ONE;
      if (frame_first) begin
        dout_q <= frame_bits[DSR_FRAME_BITS-1];
        shreg_q <= {frame_bits[DSR_FRAME_BITS-2:0], 1'b0};
      end else begin
        dout_q <= shreg_q[DSR_FRAME_BITS-1];
        shreg_q <= {shreg_q[DSR_FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  assign sample_ready = ready_q;
  assign conv_start = conv_start_q;
  assign pwr_down = pwr_down_q;
  assign dout = dout_q;
  assign dout_oe_n = dout_oe_n_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence cs_fall_seen;
    cs_lvl_q ##1 !cs_lvl_q;
  endsequence

  chk_active_when_low: assert property (@(posedge clock) disable iff (rst)
    !cs_lvl_q |=> !pwr_down_q) else $error("core not active while selected");
  chk_down_when_high: assert property (@(posedge clock) disable iff (rst)
    cs_lvl_q [*2] |-> pwr_down_q) else $error("core not powered down while deselected");
  chk_start_on_fall: assert property (@(posedge clock) disable iff (rst)
    cs_fall_seen |-> conv_start_q ##1 !conv_start_q) else $error("conversion start not a single pulse");
  chk_null_lead_bits: assert property (@(negedge sclk) disable iff (cs_n)
    (bit_cnt_q >= DSR_CNT_ONE && bit_cnt_q <= DSR_CNT_LAST_NULL) |-> !dout_q) else $error("null bit not zero");
  chk_result_msb_first: assert property (@(negedge sclk) disable iff (cs_n)
    (bit_cnt_q >= DSR_CNT_FIRST_DATA && bit_cnt_q <= DSR_CNT_FRAME)
    |-> dout_q == word_q[4'(DSR_FRAME_BITS - 32'(bit_cnt_q))]) else $error("result bit out of order");
  chk_step_per_edge: assert property (@(negedge sclk) disable iff (cs_n)
    bit_cnt_q < DSR_CNT_DONE |=> bit_cnt_q == $past(bit_cnt_q) + DSR_CNT_ONE) else $error("step count missed an edge");
  chk_sign_encode: assert property (@(posedge clock) disable iff (rst)
    pop |=> hold_q == ($past(head_code) ^ DSR_SIGN_FLIP)) else $error("result not two's complement");
  chk_drive_in_frame: assert property (@(negedge sclk) disable iff (cs_n)
    bit_cnt_q != DSR_CNT_ZERO |-> !dout_oe_n_q) else $error("output not driven inside frame");
  chk_tail_bits_zero: assert property (@(negedge sclk) disable iff (cs_n)
    bit_cnt_q == DSR_CNT_DONE |-> !dout_q) else $error("output not zero after last result bit");
  chk_start_only_fall: assert property (@(posedge clock) disable iff (rst)
    !cs_fall |=> !conv_start_q) else $error("conversion start without a select fall");

  // a full buffer must refuse, or a word is overwritten
  chk_buf_no_overflow: assert property (@(posedge clock) disable iff (rst)
    fill_q == DSR_BUF_DEPTH |-> !ready_q && !push) else $error("push taken into a full buffer");
  // serial side may copy the hold word at any time until it acknowledges
  chk_hold_word_stable: assert property (@(posedge clock) disable iff (rst)
    !hold_free |=> $stable(hold_q)) else $error("hold word changed while still offered");
endmodule
`default_nettype wire

/* tb/dsr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dsr_host
  import dsr_pkg::*;
(
  output logic sclk, // serial clock, idle high
  output logic cs_n, // chip select
  input wire logic dout, // serial data
  input wire logic dout_oe_n // low while dout driven
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
  end
  // released line reads as inverse, so a float never passes
  task automatic frame(output logic [DSR_FRAME_BITS-1:0] w);
    #7; // keeps select edges off the system clock edges
    cs_n = 1'b0;
    #30;
    for (int k = 0; k < DSR_FRAME_BITS + 2; k++) begin
      sclk = 1'b0; // steady period, never stretched or stalled inside a frame
      #24;
      sclk = 1'b1;
      if (k < DSR_FRAME_BITS) w[DSR_FRAME_BITS-1-k] = dout_oe_n ? ~dout : dout;
      #24;
    end
    cs_n = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

/* tb/dsr_readout_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dsr_readout_tb_top;
  import dsr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sample_valid = 1'b0;
  logic [DSR_RES_BITS-1:0] sample_code = DSR_WORD_RST;
  logic sclk, cs_n, sample_ready, conv_start, pwr_down, dout, dout_oe_n;
  logic [DSR_FRAME_BITS-1:0] got, last_w;
  logic [31:0] rng = 32'h9;
  int fail_count = 0, checks_done = 0, starts = 0, frames = 0;
  logic [DSR_RES_BITS-1:0] pend[$];
  always #5 clock = ~clock;
  always @(posedge clock) if (conv_start === 1'b1) starts <= starts + 1;
  dsr_readout dut_u (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sample_code(sample_code),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .conv_start(conv_start),
    .pwr_down(pwr_down), .dout(dout), .dout_oe_n(dout_oe_n));
  dsr_host host_u (.sclk(sclk), .cs_n(cs_n), .dout(dout), .dout_oe_n(dout_oe_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d failures=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ready is registered, so its negedge value is what the next posedge sees
  task automatic push();
    rng = xs(rng);
    @(posedge clock);
    sample_valid <= 1'b1;
    sample_code <= rng[DSR_RES_BITS-1:0];
    for (int n = 0; n < 2000; n++) begin
      @(negedge clock);
      if (sample_ready === 1'b1) break;
    end
    @(posedge clock);
    pend.push_back(sample_code);
    sample_valid <= 1'b0;
  endtask
  // a frame carries either the next pending word or a repeat of the last one
  task automatic frame();
    fork
      host_u.frame(got);
      begin
        repeat (40) @(negedge clock);
        check(pwr_down, 1'b0);
      end
    join
    frames++;
    if (pend.size() > 0 && got === {DSR_NULL_FILL, pend[0] ^ DSR_SIGN_FLIP}) begin
      last_w = got;
      void'(pend.pop_front());
    end
    check(got, last_w);
    repeat (10) @(negedge clock);
    check(dout_oe_n, 1'b1);
    check(pwr_down, 1'b1);
    check(starts, frames);
  endtask
  initial begin
    last_w = DSR_FRAME_RST;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      push();
      frame();
      frame();
    end
    repeat (3) push();
    repeat (4) @(negedge clock);
    check(sample_ready, 1'b0);
    @(posedge clock);
    rng = xs(rng);
    sample_valid <= 1'b1;
    sample_code <= rng[DSR_RES_BITS-1:0];
    repeat (3) @(posedge clock);
    sample_valid <= 1'b0;
    repeat (10) frame();
    check(pend.size(), 0);
    finish_test();
  end
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
